// ===== logic/cpfs_defines.svh
`ifndef CPFS_DEFINES_SVH
`define CPFS_DEFINES_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CPFS_ADDR_PORT3_DIR   16'hff23
`define CPFS_ADDR_PORT3_DATA  16'hff03
`define CPFS_ADDR_CMP_CTL     16'hff61
`define CPFS_ADDR_CMP_PC      16'hff62

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPFS_RST_PORT3_DIR    8'hff
`define CPFS_RST_PORT3_DATA   8'h00
`define CPFS_RST_CMP_CTL      8'h00
`define CPFS_RST_CMP_PC       8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPFS_PINS             5
`define CPFS_COM_PIN          1
`define CPFS_SIG_PIN          2
`define CPFS_CTL_RUN          7
`define CPFS_CTL_FILT_HI      6
`define CPFS_CTL_FILT_LO      5
`define CPFS_CTL_PIN_OUTEN    4
`define CPFS_CTL_REF_SEL      3
`define CPFS_CTL_FLAG         2
`define CPFS_CTL_OUT_EN       1
`define CPFS_CTL_INVERT       0
`define CPFS_PC_COM_DIG       1
`define CPFS_PC_SIG_DIG       0

// ----------------------------------------
// Settling times (software side), in ns and in clock cycles
// ----------------------------------------
`define CPFS_CLK_PERIOD_NS    8
`define CPFS_REF_SETTLE_NS    20000
`define CPFS_CMP_SETTLE_NS    1000
`define CPFS_REF_SETTLE_CYC   ((`CPFS_REF_SETTLE_NS + `CPFS_CLK_PERIOD_NS - 1) / `CPFS_CLK_PERIOD_NS)
`define CPFS_CMP_SETTLE_CYC   ((`CPFS_CMP_SETTLE_NS + `CPFS_CLK_PERIOD_NS - 1) / `CPFS_CLK_PERIOD_NS)

`endif

// ===== logic/cpfs_pkg.sv
package cpfs_pkg;

  // Resolved function of one shared pin
  typedef enum logic [2:0] {
    CPFS_DIG_IN,
    CPFS_DIG_OUT,
    CPFS_CMP_OFF,
    CPFS_CMP_ON,
    CPFS_BAD
  } cpfs_pin_mode_t;

endpackage

// ===== logic/cpfs_sync.sv
`timescale 1ns/1ns
`default_nettype none

module cpfs_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         srst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ----------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        meta_d[g] = ce_in ? async_in[g] : meta_q[g];
        sync_d[g] = ce_in ? meta_q[g] : sync_q[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // cpfs_sync

`default_nettype wire

// ===== logic/cpfs_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpfs_defines.svh"

module cpfs_top
  import cpfs_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic [4:0]  pin_in,
  output logic      [4:0]  pin_out,
  output logic      [4:0]  pin_oe_out,
  input  wire logic        cmp_result_in,
  output logic             cmp_run_out,
  output logic             cmp_ref_internal_out,
  output logic             cmp_signal_connect_out,
  output logic             cmp_common_connect_out,
  output logic             cmp_output_out,
  output logic             cfg_prohibited_out
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [4:0] dir_q, dir_d;
  logic [4:0] data_q, data_d;
  logic [7:0] ctl_q, ctl_d;
  logic [1:0] pc_q, pc_d;
  logic [7:0] rdata_q, rdata_d;
  logic [4:0] pin_q, pin_d;
  logic [4:0] oe_q, oe_d;
  logic       run_q, run_d;
  logic       refi_q, refi_d;
  logic       sig_q, sig_d;
  logic       com_q, com_d;
  logic       cout_q, cout_d;
  logic       bad_q, bad_d;
  logic       filt_q, filt_d;
  logic [3:0] fcnt_q, fcnt_d;

  logic [4:0] pin_s;
  logic       res_s;

  cpfs_sync #(.W(6)) u_sync (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .ce_in    (ce_in),
    .async_in ({cmp_result_in, pin_in}),
    .sync_out ({res_s, pin_s})
  );

  function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
    hit = (a == base);
  endfunction

  // ----------------------------------------
  // Pin mode decode
  // ----------------------------------------
  cpfs_pin_mode_t sig_mode, com_mode;
  logic           run, ref_int, sig_dig, com_dig;
  logic [4:0]     pin_view;
  logic [7:0]     ctl_view;
  logic [3:0]     fspan;
  logic           cmp_val;

  always_comb begin
    run     = ctl_q[`CPFS_CTL_RUN];
    ref_int = ctl_q[`CPFS_CTL_REF_SEL];
    sig_dig = pc_q[`CPFS_PC_SIG_DIG];
    com_dig = pc_q[`CPFS_PC_COM_DIG];
    // Signal pin
    if (sig_dig) begin
      if (run)
        sig_mode = CPFS_BAD;
      else
        sig_mode = dir_q[`CPFS_SIG_PIN] ? CPFS_DIG_IN : CPFS_DIG_OUT;
    end else begin
      if (!dir_q[`CPFS_SIG_PIN])
        sig_mode = CPFS_BAD;
      else
        sig_mode = run ? CPFS_CMP_ON : CPFS_CMP_OFF;
    end
    // Common pin
    if (com_dig) begin
      if (run && !ref_int)
        com_mode = CPFS_BAD;
      else
        com_mode = dir_q[`CPFS_COM_PIN] ? CPFS_DIG_IN : CPFS_DIG_OUT;
    end else begin
      if (!dir_q[`CPFS_COM_PIN])
        com_mode = CPFS_BAD;
      else
        com_mode = (run && ref_int) ? CPFS_CMP_ON : CPFS_CMP_OFF;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_comb begin
    oe_d  = ~dir_q;
    // Analog pins never drive, whatever their latch holds
    if (!sig_dig)
      oe_d[`CPFS_SIG_PIN] = 1'b0;
    if (!com_dig)
      oe_d[`CPFS_COM_PIN] = 1'b0;
    pin_d = data_q;
    // Analog pins set as inputs read back as zero on the digital side; as outputs they read the latch
    pin_view = pin_s;
    if (!sig_dig)
      pin_view[`CPFS_SIG_PIN] = 1'b0;
    if (!com_dig)
      pin_view[`CPFS_COM_PIN] = 1'b0;
    run_d  = run;
    refi_d = ref_int;
    sig_d  = (sig_mode == CPFS_CMP_ON);
    com_d  = (com_mode == CPFS_CMP_ON);
    bad_d  = (sig_mode == CPFS_BAD) || (com_mode == CPFS_BAD);
  end

  // ----------------------------------------
  // Noise filter and output gate
  // ----------------------------------------
  always_comb begin
    case (ctl_q[`CPFS_CTL_FILT_HI:`CPFS_CTL_FILT_LO])
      2'h0:    fspan = 4'h0;
      2'h1:    fspan = 4'h2;
      2'h2:    fspan = 4'h4;
      default: fspan = 4'h8;
    endcase
    filt_d = filt_q;
    fcnt_d = 4'h0;
    // Result only takes effect after standing for the chosen span
    if (!run) begin
      filt_d = 1'b0;
    end else if (fspan == 4'h0) begin
      filt_d = res_s;
    end else if (res_s != filt_q) begin
      fcnt_d = fcnt_q + 4'h1;
      if (fcnt_d >= fspan) begin
        filt_d = res_s;
        fcnt_d = 4'h0;
      end
    end
    cmp_val = filt_q ^ ctl_q[`CPFS_CTL_INVERT];
    cout_d  = ctl_q[`CPFS_CTL_OUT_EN] & run & cmp_val;
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always_comb begin
    dir_d   = dir_q;
    data_d  = data_q;
    ctl_d   = ctl_q;
    pc_d    = pc_q;
    rdata_d = rdata_q;
    ctl_view = ctl_q;
    ctl_view[`CPFS_CTL_FLAG] = cmp_val;
    if (wr_in) begin
      if (hit(addr_in, `CPFS_ADDR_PORT3_DIR))
        dir_d = wdata_in[4:0];
      if (hit(addr_in, `CPFS_ADDR_PORT3_DATA))
        data_d = wdata_in[4:0];
      if (hit(addr_in, `CPFS_ADDR_CMP_CTL))
        ctl_d = {wdata_in[7:3], 1'b0, wdata_in[1:0]};
      if (hit(addr_in, `CPFS_ADDR_CMP_PC))
        pc_d = wdata_in[1:0];
    end
    if (rd_in) begin
      if (hit(addr_in, `CPFS_ADDR_PORT3_DIR))
        rdata_d = {3'h7, dir_q};
      else if (hit(addr_in, `CPFS_ADDR_PORT3_DATA))
        rdata_d = {3'h0, (dir_q & pin_view) | (~dir_q & data_q)};
      else if (hit(addr_in, `CPFS_ADDR_CMP_CTL))
        rdata_d = ctl_view;
      else if (hit(addr_in, `CPFS_ADDR_CMP_PC))
        rdata_d = {6'h00, pc_q};
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dir_q   <= 5'(`CPFS_RST_PORT3_DIR);
      data_q  <= 5'(`CPFS_RST_PORT3_DATA);
      ctl_q   <= `CPFS_RST_CMP_CTL;
      pc_q    <= 2'(`CPFS_RST_CMP_PC);
      rdata_q <= 8'h00;
      pin_q   <= 5'h00;
      oe_q    <= 5'h00;
      run_q   <= 1'b0;
      refi_q  <= 1'b0;
      sig_q   <= 1'b0;
      com_q   <= 1'b0;
      cout_q  <= 1'b0;
      bad_q   <= 1'b0;
      filt_q  <= 1'b0;
      fcnt_q  <= 4'h0;
    end else if (ce_in) begin
      dir_q   <= dir_d;
      data_q  <= data_d;
      ctl_q   <= ctl_d;
      pc_q    <= pc_d;
      rdata_q <= rdata_d;
      pin_q   <= pin_d;
      oe_q    <= oe_d;
      run_q   <= run_d;
      refi_q  <= refi_d;
      sig_q   <= sig_d;
      com_q   <= com_d;
      cout_q  <= cout_d;
      bad_q   <= bad_d;
      filt_q  <= filt_d;
      fcnt_q  <= fcnt_d;
    end
  end

  assign rdata_out              = rdata_q;
  assign pin_out                = pin_q;
  assign pin_oe_out             = oe_q;
  assign cmp_run_out            = run_q;
  assign cmp_ref_internal_out   = refi_q;
  assign cmp_signal_connect_out = sig_q;
  assign cmp_common_connect_out = com_q;
  assign cmp_output_out         = cout_q;
  assign cfg_prohibited_out     = bad_q;

endmodule // cpfs_top

`default_nettype wire

// ===== test/cpfs_analog_env.sv
`timescale 1ns/1ns
`default_nettype none
module cpfs_analog_env #(
  parameter int VREG_MV = 1200
) (
  input  wire logic        mclk_in,
  input  wire logic [4:0]  pin_out_in,
  input  wire logic [4:0]  pin_oe_in,
  input  wire logic [4:0]  ext_lvl_in,
  input  wire logic        run_in,
  input  wire logic        ref_int_in,
  input  wire logic [15:0] sig_mv_in,
  input  wire logic [15:0] com_mv_in,
  output logic      [4:0]  pin_lvl_out,
  output logic             result_out
);
  logic junk_q = 1'b0;
  always @(posedge mclk_in) junk_q <= ~junk_q;
  // A pin whose buffer is off shows the outside level, never the latch
  assign pin_lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_lvl_in);
  // A stopped comparator gives no usable decision, so it wanders every cycle
  assign result_out = !run_in ? junk_q : (sig_mv_in > (ref_int_in ? 16'(VREG_MV) : com_mv_in));
endmodule // cpfs_analog_env
`default_nettype wire

// ===== test/cpfs_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cpfs_top_chk (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic [4:0]  pin_oe_out,
  input wire logic        cmp_run_out,
  input wire logic        cmp_ref_internal_out,
  input wire logic        cmp_signal_connect_out,
  input wire logic        cmp_common_connect_out,
  input wire logic        cmp_output_out,
  input wire logic        cfg_prohibited_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  wire dir_wr = wr_in && addr_in == 16'hff23;
  wire ctl_wr = wr_in && addr_in == 16'hff61;
  a_reset_idle: assert property ($fell(srst_in) |-> pin_oe_out == 5'h00 && !cmp_output_out)
    else $error("outputs not idle after reset");
  a_oe_dir_map: assert property (dir_wr |-> ##3
    {pin_oe_out[4:3], pin_oe_out[0]} == ~{$past(wdata_in[4:3], 3), $past(wdata_in[0], 3)})
    else $error("buffer enable does not follow direction");
  a_read_dir_top: assert property (rd_in && addr_in == 16'hff23 |-> ##2 rdata_out[7:5] == 3'h7)
    else $error("direction upper bits not one");
  a_sig_connect: assert property (cmp_signal_connect_out |-> cmp_run_out && !pin_oe_out[2])
    else $error("signal pin connected while driving");
  a_com_connect: assert property (cmp_common_connect_out |-> cmp_run_out && cmp_ref_internal_out && !pin_oe_out[1])
    else $error("common pin connected wrongly");
  a_sig_prohib: assert property (cmp_run_out && pin_oe_out[2] |-> cfg_prohibited_out)
    else $error("signal pin misuse not flagged");
  a_com_prohib: assert property (cmp_run_out && !cmp_ref_internal_out && pin_oe_out[1] |-> cfg_prohibited_out)
    else $error("common pin misuse not flagged");
  a_out_gated: assert property (ctl_wr && !wdata_in[1] |-> ##3 !cmp_output_out [*2])
    else $error("output not held low");
  a_run_ref_sel: assert property (ctl_wr |-> ##3
    cmp_run_out == $past(wdata_in[7], 3) && cmp_ref_internal_out == $past(wdata_in[3], 3))
    else $error("run or reference select wrong");
  c_out_on: cover property ($rose(cmp_output_out));
  c_prohib: cover property (cfg_prohibited_out);
  c_com_on: cover property (cmp_common_connect_out);
endmodule // cpfs_top_chk
`default_nettype wire

// ===== test/cpfs_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpfs_defines.svh"
module cpfs_top_bench;
  logic        mclk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        rd_d = 1'b0;
  logic        rd_dd = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00;
  logic [4:0]  ext_lvl = 5'h00;
  logic [15:0] sig_mv = 16'h0000;
  logic [15:0] com_mv = 16'h0000;
  logic [7:0]  rdata_out;
  logic [4:0]  pin_in, pin_out, pin_oe_out;
  logic        cmp_result_in, cmp_run_out, cmp_ref_internal_out, cmp_output_out, cfg_prohibited_out;
  logic        cmp_signal_connect_out, cmp_common_connect_out;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [7:0]  exp_q[$];
  // Control, direction, pin select, then expected prohibited, signal and common connect
  logic [20:0] tbl [8] = '{{8'h80, 8'hfb, 2'h1, 3'h4}, {8'h00, 8'hfb, 2'h0, 3'h4},
                          {8'h80, 8'hfd, 2'h2, 3'h6}, {8'h88, 8'hff, 2'h2, 3'h2},
                          {8'h88, 8'hff, 2'h0, 3'h3}, {8'h80, 8'hff, 2'h0, 3'h2},
                          {8'h00, 8'hfd, 2'h0, 3'h4}, {8'h00, 8'he0, 2'h3, 3'h0}};

  cpfs_top u_dut (.mclk_in, .srst_in, .ce_in(1'b1), .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pin_in,
    .pin_out, .pin_oe_out, .cmp_result_in, .cmp_run_out, .cmp_ref_internal_out, .cmp_signal_connect_out,
    .cmp_common_connect_out, .cmp_output_out, .cfg_prohibited_out);
  cpfs_analog_env u_env (.mclk_in, .pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .ext_lvl_in(ext_lvl),
    .run_in(cmp_run_out), .ref_int_in(cmp_ref_internal_out), .sig_mv_in(sig_mv), .com_mv_in(com_mv),
    .pin_lvl_out(pin_in), .result_out(cmp_result_in));

  always #4 mclk_in = ~mclk_in;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  // An idle cycle after each access keeps two results from landing in one check window
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr_in = a;
    wdata_in = d;
    wr_in = w;
    rd_in = !w;
    if (!w) exp_q.push_back(d);
    @(negedge mclk_in);
    wr_in = 1'b0;
    rd_in = 1'b0;
    @(negedge mclk_in);
  endtask

  task automatic wait_out(input logic v);
    int k;
    for (k = 0; k < 40 && cmp_output_out !== v; k++) @(negedge mclk_in);
    chk("cmp_out", cmp_output_out, v);
    if (k == 40) give_verdict();
  endtask

  always @(posedge mclk_in) begin
    rd_d <= rd_in;
    rd_dd <= rd_d;
  end
  always @(negedge mclk_in) begin
    if (rd_dd) chk("rdata", rdata_out, exp_q.pop_front());
  end

  initial begin
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] d;
    logic [1:0] p;
    logic [2:0] e;
    void'($urandom(32'h5cd4));
    wt(20);
    srst_in = 1'b0;
    wt(2);
    chk("oe", pin_oe_out, 8'h00);
    bus(1'b0, `CPFS_ADDR_PORT3_DIR, 8'hff);
    bus(1'b0, `CPFS_ADDR_CMP_PC, 8'h00);
    bus(1'b0, 16'hff70, 8'h00);
    $display("test reset done");
    bus(1'b1, `CPFS_ADDR_CMP_PC, 8'h03);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) | 8'he0;
      ext_lvl = 5'($urandom);
      bus(1'b1, `CPFS_ADDR_PORT3_DIR, v);
      bus(1'b1, `CPFS_ADDR_PORT3_DATA, ~v);
      wt(2);
      chk("oe", pin_oe_out, {3'h0, ~v[4:0]});
      chk("latch", pin_out, {3'h0, ~v[4:0]});
      bus(1'b0, `CPFS_ADDR_PORT3_DIR, v);
      bus(1'b0, `CPFS_ADDR_PORT3_DATA, {3'h0, (v[4:0] & ext_lvl) | ~v[4:0]});
    end
    $display("test direction done");
    foreach (tbl[i]) begin
      {c, d, p, e} = tbl[i];
      bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h00);
      bus(1'b1, `CPFS_ADDR_CMP_PC, {6'h00, p});
      bus(1'b1, `CPFS_ADDR_PORT3_DIR, d);
      bus(1'b1, `CPFS_ADDR_CMP_CTL, c);
      wt(2);
      chk("prohib", cfg_prohibited_out, e[2]);
      chk("sig", cmp_signal_connect_out, e[1]);
      chk("com", cmp_common_connect_out, e[0]);
      chk("run", cmp_run_out, c[7]);
      chk("ref", cmp_ref_internal_out, c[3]);
      chk("oe", pin_oe_out, ~d[4:0] & {2'h3, p[0], p[1], 1'b1});
    end
    $display("test pin table done");
    bus(1'b1, `CPFS_ADDR_CMP_PC, 8'h00);
    bus(1'b1, `CPFS_ADDR_PORT3_DIR, 8'hff);
    sig_mv = 16'd1500;
    bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h88);
    wt(`CPFS_REF_SETTLE_CYC);
    chk("gated", cmp_output_out, 8'h00);
    bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h8a);
    wait_out(1'b1);
    bus(1'b0, `CPFS_ADDR_CMP_CTL, 8'h8e);
    sig_mv = 16'd900;
    wait_out(1'b0);
    bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h88);
    bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h00);
    com_mv = 16'd600;
    bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h80);
    wt(`CPFS_CMP_SETTLE_CYC);
    bus(1'b1, `CPFS_ADDR_CMP_CTL, 8'h82);
    wait_out(1'b1);
    com_mv = 16'd1000;
    wait_out(1'b0);
    $display("test comparator done");
    give_verdict();
  end
endmodule // cpfs_top_bench

bind cpfs_top cpfs_top_chk u_chk (.mclk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pin_oe_out,
  .cmp_run_out, .cmp_ref_internal_out, .cmp_signal_connect_out, .cmp_common_connect_out, .cmp_output_out,
  .cfg_prohibited_out);
`default_nettype wire
